//--- design/tocu_pkg.sv
// Package for the timer output compare unit: register map, field layout, codes
package tocu_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] OFF_MODE = 3'h0;
  localparam logic [2:0] OFF_ACTION = 3'h1;
  localparam logic [2:0] OFF_COUNTER = 3'h2;
  localparam logic [2:0] OFF_COMPARE_A = 3'h3;
  localparam logic [2:0] OFF_COMPARE_B = 3'h4;
  localparam logic [2:0] OFF_FLAGS = 3'h5;
  localparam logic [2:0] OFF_IRQ_EN = 3'h6;
  localparam logic [2:0] OFF_STATE = 3'h7;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_WGM_LSB = 0;
  localparam int MODE_CS_LSB = 3;
  localparam int ACT_A_LSB = 0;
  localparam int ACT_B_LSB = 2;
  localparam int FORCE_A_BIT = 6;
  localparam int FORCE_B_BIT = 7;
  localparam int FLAG_OVF = 0;
  localparam int FLAG_A = 1;
  localparam int FLAG_B = 2;

  // ----------------------------------------------------------------
  // Count limits and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_FLAGS = 3'h0;

  // ----------------------------------------------------------------
  // Waveform modes and compare output actions
  // ----------------------------------------------------------------
  localparam logic [2:0] WGM_NORMAL = 3'h0;
  localparam logic [2:0] WGM_CLEAR_ON_MATCH = 3'h2;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  typedef enum logic [1:0] {
    KIND_PLAIN,
    KIND_FAST,
    KIND_PHASE
  } tocu_kind_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } tocu_bus_req_t;

  typedef struct packed {
    logic out_a;
    logic out_b;
    logic dir_a;
    logic dir_b;
  } tocu_port_t;

  typedef struct packed {
    logic out_a;
    logic oe_a;
    logic out_b;
    logic oe_b;
  } tocu_pin_t;

endpackage

//--- design/tocu_timer.sv
// Output compare unit, counter and register port of an 8-bit timer
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module tocu_timer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Timer tick from the prescaler, same clock domain
  input wire logic timer_tick,
  // Register port
  input wire tocu_pkg::tocu_bus_req_t bus_req,
  output logic [7:0] rdata,
  // Interrupt requests and service acknowledges, bit order ovf, a, b
  output logic [2:0] irq,
  input wire logic [2:0] irq_ack,
  // General port logic and compare pins
  input wire tocu_pkg::tocu_port_t port_in,
  output tocu_pkg::tocu_pin_t pin
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cnt;
    logic down;
    logic [7:0] ocr_a;
    logic [7:0] ocr_b;
    logic [7:0] buf_a;
    logic [7:0] buf_b;
    logic [2:0] wgm;
    logic [2:0] cs;
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic [2:0] flags;
    logic [2:0] irq_en;
    logic out_a;
    logic out_b;
    logic block;
    logic [7:0] rdata;
  } tocu_state_t;

  tocu_state_t st;
  tocu_state_t next_st;

  // ----------------------------------------------------------------
  // Waveform generator step for one unit
  // ----------------------------------------------------------------
  function automatic logic wave_next(input logic cur, input logic [1:0] com, input logic hit,
                                     input tocu_pkg::tocu_kind_t kind, input logic bottom_evt,
                                     input logic down, input logic toggle_ok);
    logic res;
    res = cur;
    if (com != tocu_pkg::ACT_NONE) begin
      unique case (kind)
        tocu_pkg::KIND_PLAIN: begin
          if (hit) begin
            res = (com == tocu_pkg::ACT_TOGGLE) ? ~cur : (com == tocu_pkg::ACT_SET);
          end
        end
        tocu_pkg::KIND_FAST: begin
          if (com == tocu_pkg::ACT_TOGGLE) begin
            res = (toggle_ok && hit) ? ~cur : cur;
          end else if (bottom_evt) begin
            res = (com == tocu_pkg::ACT_CLEAR);
          end else if (hit) begin
            res = (com == tocu_pkg::ACT_SET);
          end
        end
        tocu_pkg::KIND_PHASE: begin
          if (com == tocu_pkg::ACT_TOGGLE) begin
            res = (toggle_ok && hit) ? ~cur : cur;
          end else if (hit) begin
            res = (com == tocu_pkg::ACT_CLEAR) ? down : ~down;
          end
        end
        default: begin
          res = cur;
        end
      endcase
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Decode of mode, tick and matches
  // ----------------------------------------------------------------
  logic pwm;
  logic clear_on_match_mode;
  tocu_pkg::tocu_kind_t kind;
  logic [7:0] top;
  logic tick_en;
  logic match_a;
  logic match_b;
  logic hit_a;
  logic hit_b;
  logic wave_hit_a;
  logic wave_hit_b;
  logic at_top;
  logic fast_wrap;
  logic wr_mode;
  logic wr_action;
  logic wr_cnt;
  logic wr_cmp_a;
  logic wr_cmp_b;
  logic wr_flags;
  logic wr_irq_en;
  logic force_a;
  logic force_b;
  logic [1:0] new_com_a;
  logic [1:0] new_com_b;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;
  logic [7:0] count_next;
  logic down_next;

  assign pwm = st.wgm[0];
  assign clear_on_match_mode = (st.wgm == tocu_pkg::WGM_CLEAR_ON_MATCH);
  assign kind = !pwm ? tocu_pkg::KIND_PLAIN :
                (st.wgm[1] ? tocu_pkg::KIND_FAST : tocu_pkg::KIND_PHASE);
  // Top is maximum, or compare A in clear-on-match and the upper PWM modes
  assign top = (st.wgm[2] || clear_on_match_mode) ? st.ocr_a : tocu_pkg::CNT_MAX;
  // Stopped clock source means no ticks at all
  assign tick_en = timer_tick && (st.cs != 3'h0);
  assign match_a = (st.cnt == st.ocr_a);
  assign match_b = (st.cnt == st.ocr_b);
  assign hit_a = tick_en && match_a && !st.block;
  assign hit_b = tick_en && match_b && !st.block;
  // A compare at maximum in fast PWM would cut a one-tick notch; skip it for a steady level
  assign wave_hit_a = (hit_a && !((kind == tocu_pkg::KIND_FAST) &&
                      (st.ocr_a == tocu_pkg::CNT_MAX))) || force_a;
  assign wave_hit_b = (hit_b && !((kind == tocu_pkg::KIND_FAST) &&
                      (st.ocr_b == tocu_pkg::CNT_MAX))) || force_b;
  assign at_top = (st.cnt == top);
  assign fast_wrap = tick_en && (kind == tocu_pkg::KIND_FAST) && at_top;

  assign wr_mode = bus_req.we && (bus_req.addr == tocu_pkg::OFF_MODE);
  assign wr_action = bus_req.we && (bus_req.addr == tocu_pkg::OFF_ACTION);
  assign wr_cnt = bus_req.we && (bus_req.addr == tocu_pkg::OFF_COUNTER);
  assign wr_cmp_a = bus_req.we && (bus_req.addr == tocu_pkg::OFF_COMPARE_A);
  assign wr_cmp_b = bus_req.we && (bus_req.addr == tocu_pkg::OFF_COMPARE_B);
  assign wr_flags = bus_req.we && (bus_req.addr == tocu_pkg::OFF_FLAGS);
  assign wr_irq_en = bus_req.we && (bus_req.addr == tocu_pkg::OFF_IRQ_EN);
  // Force strobes only act outside PWM modes
  assign force_a = wr_action && bus_req.wdata[tocu_pkg::FORCE_A_BIT] && !pwm;
  assign force_b = wr_action && bus_req.wdata[tocu_pkg::FORCE_B_BIT] && !pwm;
  // A force in the same write as new action bits uses the new ones
  assign new_com_a = force_a ? bus_req.wdata[tocu_pkg::ACT_A_LSB +: 2] : st.com_a;
  assign new_com_b = force_b ? bus_req.wdata[tocu_pkg::ACT_B_LSB +: 2] : st.com_b;

  // ----------------------------------------------------------------
  // Count sequence, from mode bits, compare A and count direction
  // ----------------------------------------------------------------
  always_comb begin
    count_next = 8'(st.cnt + 8'h01);
    down_next = 1'b0;
    unique case (kind)
      tocu_pkg::KIND_PLAIN: begin
        if (clear_on_match_mode && match_a) begin
          count_next = tocu_pkg::CNT_BOTTOM;
        end
      end
      tocu_pkg::KIND_FAST: begin
        if (at_top) begin
          count_next = tocu_pkg::CNT_BOTTOM;
        end
      end
      tocu_pkg::KIND_PHASE: begin
        down_next = st.down;
        if (!st.down && at_top) begin
          down_next = 1'b1;
          count_next = 8'(st.cnt - 8'h01);
        end else if (st.down && (st.cnt == tocu_pkg::CNT_BOTTOM)) begin
          down_next = 1'b0;
        end else if (st.down) begin
          count_next = 8'(st.cnt - 8'h01);
        end
      end
      default: begin
        count_next = st.cnt;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Flag sources
  // ----------------------------------------------------------------
  always_comb begin
    flag_set = 3'h0;
    flag_set[tocu_pkg::FLAG_A] = hit_a;
    flag_set[tocu_pkg::FLAG_B] = hit_b;
    unique case (kind)
      tocu_pkg::KIND_PLAIN: flag_set[tocu_pkg::FLAG_OVF] =
        tick_en && !wr_cnt && (st.cnt == tocu_pkg::CNT_MAX);
      tocu_pkg::KIND_FAST: flag_set[tocu_pkg::FLAG_OVF] = tick_en && !wr_cnt && at_top;
      tocu_pkg::KIND_PHASE: flag_set[tocu_pkg::FLAG_OVF] =
        tick_en && !wr_cnt && st.down && (st.cnt == tocu_pkg::CNT_BOTTOM);
      default: flag_set[tocu_pkg::FLAG_OVF] = 1'b0;
    endcase
    // Write-one clears from software and service acknowledges
    flag_clr = irq_ack | (wr_flags ? bus_req.wdata[2:0] : 3'h0);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rdata = tocu_pkg::RST_BYTE;

    // Counter: a processor write wins over counting
    if (wr_cnt) begin
      next_st.cnt = bus_req.wdata;
      next_st.block = 1'b1;
    end else if (tick_en) begin
      next_st.cnt = count_next;
      next_st.down = down_next;
      next_st.block = 1'b0;
    end

    // Buffer transfer at top in PWM modes
    if (tick_en && pwm && at_top) begin
      next_st.ocr_a = st.buf_a;
      next_st.ocr_b = st.buf_b;
    end
    if (wr_cmp_a) begin
      next_st.buf_a = bus_req.wdata;
      if (!pwm) begin
        next_st.ocr_a = bus_req.wdata;
      end
    end
    if (wr_cmp_b) begin
      next_st.buf_b = bus_req.wdata;
      if (!pwm) begin
        next_st.ocr_b = bus_req.wdata;
      end
    end

    // Control registers; mode change leaves output states alone
    if (wr_mode) begin
      next_st.wgm = bus_req.wdata[tocu_pkg::MODE_WGM_LSB +: 3];
      next_st.cs = bus_req.wdata[tocu_pkg::MODE_CS_LSB +: 3];
    end
    if (wr_action) begin
      next_st.com_a = bus_req.wdata[tocu_pkg::ACT_A_LSB +: 2];
      next_st.com_b = bus_req.wdata[tocu_pkg::ACT_B_LSB +: 2];
    end
    if (wr_irq_en) begin
      next_st.irq_en = bus_req.wdata[2:0];
    end

    // Set wins over a clear in the same cycle
    next_st.flags = (st.flags & ~flag_clr) | flag_set;

    // Waveform generator; action bits used are those standing at the match
    next_st.out_a = wave_next(st.out_a, new_com_a, wave_hit_a, kind, fast_wrap, st.down,
                              st.wgm[2]);
    next_st.out_b = wave_next(st.out_b, new_com_b, wave_hit_b, kind, fast_wrap, st.down,
                              1'b0);

    // Read data stands one cycle after the strobe
    if (bus_req.re) begin
      unique case (bus_req.addr)
        tocu_pkg::OFF_MODE: next_st.rdata = {2'h0, st.cs, st.wgm};
        tocu_pkg::OFF_ACTION: next_st.rdata = {4'h0, st.com_b, st.com_a};
        tocu_pkg::OFF_COUNTER: next_st.rdata = st.cnt;
        tocu_pkg::OFF_COMPARE_A: next_st.rdata = pwm ? st.buf_a : st.ocr_a;
        tocu_pkg::OFF_COMPARE_B: next_st.rdata = pwm ? st.buf_b : st.ocr_b;
        tocu_pkg::OFF_FLAGS: next_st.rdata = {5'h0, st.flags};
        tocu_pkg::OFF_IRQ_EN: next_st.rdata = {5'h0, st.irq_en};
        tocu_pkg::OFF_STATE: next_st.rdata = {5'h0, st.down, st.out_b, st.out_a};
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata = st.rdata;
  assign irq = st.flags & st.irq_en;
  // Port override follows action bits in any mode; direction stays with the port
  assign pin.out_a = (st.com_a != tocu_pkg::ACT_NONE) ? st.out_a : port_in.out_a;
  assign pin.out_b = (st.com_b != tocu_pkg::ACT_NONE) ? st.out_b : port_in.out_b;
  assign pin.oe_a = port_in.dir_a;
  assign pin.oe_b = port_in.dir_b;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_flag_a_late: assert property (@(posedge clk_sys) disable iff (!rstn)
    (tick_en && match_a && !st.block) |=> st.flags[tocu_pkg::FLAG_A])
    else $error("compare flag a not set after match");

  a_flag_a_cause: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(st.flags[tocu_pkg::FLAG_A]) |-> $past(tick_en && (st.cnt == st.ocr_a)))
    else $error("compare flag a rose without a match");

  a_write_block: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st.block && tick_en) |=> !$rose(st.flags[tocu_pkg::FLAG_B]))
    else $error("match not blocked after counter write");

  a_flag_w1c: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_flags && bus_req.wdata[tocu_pkg::FLAG_B] && !hit_b) |=> !st.flags[tocu_pkg::FLAG_B])
    else $error("write one did not clear flag b");

  a_ack_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
    (irq_ack[tocu_pkg::FLAG_A] && !hit_a) |=> !irq[tocu_pkg::FLAG_A])
    else $error("serviced interrupt still pending");

  a_force_toggle: assert property (@(posedge clk_sys) disable iff (!rstn)
    (force_a && (new_com_a == tocu_pkg::ACT_TOGGLE) && !hit_a)
      |=> (st.out_a != $past(st.out_a)) && !$rose(st.flags[tocu_pkg::FLAG_A]))
    else $error("force strobe wrong on output a");

  a_action_none: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st.com_b == tocu_pkg::ACT_NONE && !wr_action) |=> $stable(st.out_b))
    else $error("output b moved with no action");

  a_normal_wrap: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st.wgm == tocu_pkg::WGM_NORMAL && tick_en && st.cnt == tocu_pkg::CNT_MAX && !wr_cnt)
      |=> (st.cnt == tocu_pkg::CNT_BOTTOM) && st.flags[tocu_pkg::FLAG_OVF])
    else $error("normal mode wrap or overflow flag wrong");

  a_cnt_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_cnt |=> (st.cnt == $past(bus_req.wdata)) ##1 (st.block || $past(tick_en)))
    else $error("counter write lost");

  a_stopped: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st.cs == 3'h0 && !wr_cnt) |=> $stable(st.cnt))
    else $error("counter moved while stopped");

  a_buffered: assert property (@(posedge clk_sys) disable iff (!rstn)
    (pwm && wr_cmp_a && !(tick_en && at_top)) |=> $stable(st.ocr_a))
    else $error("pwm compare write bypassed buffer");

endmodule

`default_nettype wire

//--- verif/tocu_port_model.sv
// Port pin logic beside the timer: software port settings and pad levels
`timescale 1ns/1ps
`default_nettype none

module tocu_port_model (
  // Port settings written by software
  input wire logic out_a,
  input wire logic out_b,
  input wire logic dir_a,
  input wire logic dir_b,
  // Port side of the timer
  output tocu_pkg::tocu_port_t port_in,
  input wire tocu_pkg::tocu_pin_t pin,
  // Pad levels
  output logic pad_a,
  output logic pad_b
);
  // Direction stays with software; it is set only after the state is prepared
  assign port_in = '{out_a: out_a, out_b: out_b, dir_a: dir_a, dir_b: dir_b};
  // Pads carry a pull-up, so an undriven pin reads high, never a stale level
  assign pad_a = pin.oe_a ? pin.out_a : 1'b1;
  assign pad_b = pin.oe_b ? pin.out_b : 1'b1;
endmodule

`default_nettype wire

//--- verif/tb_tocu_timer.sv
// Self-checking testbench of the timer output compare unit
`timescale 1ns/1ps
`default_nettype none

module tb_tocu_timer;
  logic clk_sys;
  logic rstn;
  logic timer_tick;
  tocu_pkg::tocu_bus_req_t bus_req;
  logic [7:0] rdata;
  logic [2:0] irq;
  logic [2:0] irq_ack;
  tocu_pkg::tocu_port_t port_in;
  tocu_pkg::tocu_pin_t pin;
  logic p_out_a;
  logic p_out_b;
  logic p_dir_a;
  logic p_dir_b;
  logic pad_a;
  logic pad_b;
  int n_mismatch;
  int n_compared;
  logic [1:0] acts [5];
  logic ea;
  logic eb;

  tocu_timer tocu_timer_inst (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .timer_tick(timer_tick),
    .bus_req(bus_req),
    .rdata(rdata),
    .irq(irq),
    .irq_ack(irq_ack),
    .port_in(port_in),
    .pin(pin)
  );

  tocu_port_model tocu_port_model_inst (
    .out_a(p_out_a),
    .out_b(p_out_b),
    .dir_a(p_dir_a),
    .dir_b(p_dir_b),
    .port_in(port_in),
    .pin(pin),
    .pad_a(pad_a),
    .pad_b(pad_b)
  );

  always #12.5 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // Bus, tick and check tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // A spare cycle after each access keeps strobes from being set twice in one step
  task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic tk = 1'b0);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    timer_tick <= tk;
    @(posedge clk_sys);
    bus_req <= '0;
    timer_tick <= 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic rd_chk(input string what, input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge clk_sys);
    bus_req <= '0;
    @(negedge clk_sys);
    check(what, rdata, exp);
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      timer_tick <= 1'b1;
      @(posedge clk_sys);
      timer_tick <= 1'b0;
      @(negedge clk_sys);
    end
  endtask

  task automatic ack(input logic [2:0] m);
    @(posedge clk_sys);
    irq_ack <= m;
    @(posedge clk_sys);
    irq_ack <= 3'h0;
    @(negedge clk_sys);
  endtask

  function automatic logic next_out(input logic s, input logic [1:0] act);
    case (act)
      tocu_pkg::ACT_SET: next_out = 1'b1;
      tocu_pkg::ACT_CLEAR: next_out = 1'b0;
      tocu_pkg::ACT_TOGGLE: next_out = ~s;
      default: next_out = s;
    endcase
  endfunction

  task automatic end_sim;
    $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Whole run is well under 1000 cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    rstn = 1'b0;
    timer_tick = 1'b0;
    bus_req = '0;
    irq_ack = 3'h0;
    p_out_a = 1'b1;
    p_out_b = 1'b0;
    p_dir_a = 1'b0;
    p_dir_b = 1'b0;
    n_mismatch = 0;
    n_compared = 0;
    acts = '{tocu_pkg::ACT_SET, tocu_pkg::ACT_CLEAR, tocu_pkg::ACT_TOGGLE,
             tocu_pkg::ACT_NONE, tocu_pkg::ACT_TOGGLE};
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    @(negedge clk_sys);
    rd_chk("state", tocu_pkg::OFF_STATE, 8'h00);
    rd_chk("flags", tocu_pkg::OFF_FLAGS, 8'h00);
    check("pin a", {7'h00, pin.out_a}, 8'h01);
    check("pad b", {6'h00, pin.oe_b, pad_b}, 8'h01);
    check("pad a off", {6'h00, pin.oe_a, pad_a}, 8'h01);
    // Forced actions on both units, stopped timer, normal mode
    ea = 1'b0;
    eb = 1'b0;
    for (int i = 0; i < 5; i++) begin
      ea = next_out(ea, acts[i]);
      eb = next_out(eb, acts[i]);
      wr(tocu_pkg::OFF_ACTION, {6'h10, acts[i]});
      // Pin a becomes an output only once its state has been forced
      if (i == 0) begin
        @(posedge clk_sys);
        p_dir_a <= 1'b1;
        @(negedge clk_sys);
      end
      check("pin a", {7'h00, pin.out_a}, {7'h00, (acts[i] != 2'h0) ? ea : p_out_a});
      check("pad a", {7'h00, pad_a}, {7'h00, (acts[i] != 2'h0) ? ea : p_out_a});
      wr(tocu_pkg::OFF_ACTION, {4'h8, acts[i], 2'h0});
      check("pin b", {7'h00, pin.out_b}, {7'h00, (acts[i] != 2'h0) ? eb : p_out_b});
      check("pin a back", {7'h00, pin.out_a}, {7'h00, p_out_a});
      rd_chk("forced state", tocu_pkg::OFF_STATE, {6'h00, eb, ea});
      rd_chk("forced flags", tocu_pkg::OFF_FLAGS, 8'h00);
    end
    // Matches, blocking after counter write, flags and interrupts
    wr(tocu_pkg::OFF_COMPARE_A, 8'h05);
    wr(tocu_pkg::OFF_COMPARE_B, 8'h05);
    rd_chk("compare a", tocu_pkg::OFF_COMPARE_A, 8'h05);
    wr(tocu_pkg::OFF_IRQ_EN, 8'h07);
    wr(tocu_pkg::OFF_ACTION, {6'h00, tocu_pkg::ACT_TOGGLE});
    wr(tocu_pkg::OFF_COUNTER, 8'h05);
    tick(1);
    rd_chk("stopped count", tocu_pkg::OFF_COUNTER, 8'h05);
    wr(tocu_pkg::OFF_MODE, 8'h08);
    tick(1);
    rd_chk("blocked flags", tocu_pkg::OFF_FLAGS, 8'h00);
    rd_chk("count up", tocu_pkg::OFF_COUNTER, 8'h06);
    wr(tocu_pkg::OFF_COUNTER, 8'h04);
    tick(2);
    rd_chk("match flags", tocu_pkg::OFF_FLAGS, 8'h06);
    check("irq", {5'h00, irq}, 8'h06);
    rd_chk("toggled", tocu_pkg::OFF_STATE, 8'h01);
    wr(tocu_pkg::OFF_FLAGS, 8'h00);
    rd_chk("zero write", tocu_pkg::OFF_FLAGS, 8'h06);
    wr(tocu_pkg::OFF_FLAGS, 8'h02);
    rd_chk("one write", tocu_pkg::OFF_FLAGS, 8'h04);
    wr(tocu_pkg::OFF_ACTION, {6'h00, tocu_pkg::ACT_CLEAR});
    rd_chk("no early act", tocu_pkg::OFF_STATE, 8'h01);
    wr(tocu_pkg::OFF_COUNTER, 8'h04);
    tick(2);
    rd_chk("new action", tocu_pkg::OFF_STATE, 8'h00);
    check("pin cleared", {7'h00, pin.out_a}, 8'h00);
    ack(3'h6);
    rd_chk("serviced", tocu_pkg::OFF_FLAGS, 8'h00);
    check("irq off", {5'h00, irq}, 8'h00);
    // Overflow and write priority
    wr(tocu_pkg::OFF_COUNTER, 8'hfe, 1'b1);
    rd_chk("write wins", tocu_pkg::OFF_COUNTER, 8'hfe);
    tick(1);
    rd_chk("no ovf yet", tocu_pkg::OFF_FLAGS, 8'h00);
    tick(1);
    rd_chk("wrap", tocu_pkg::OFF_COUNTER, 8'h00);
    rd_chk("ovf", tocu_pkg::OFF_FLAGS, 8'h01);
    check("irq ovf", {5'h00, irq}, 8'h01);
    ack(3'h1);
    rd_chk("ovf serviced", tocu_pkg::OFF_FLAGS, 8'h00);
    // Mode change, ignored force and double buffering
    wr(tocu_pkg::OFF_ACTION, 8'h43);
    wr(tocu_pkg::OFF_MODE, 8'h0b);
    rd_chk("kept state", tocu_pkg::OFF_STATE, 8'h01);
    wr(tocu_pkg::OFF_ACTION, 8'h42);
    rd_chk("pwm force", tocu_pkg::OFF_STATE, 8'h01);
    wr(tocu_pkg::OFF_COMPARE_B, 8'h10);
    rd_chk("buffer b", tocu_pkg::OFF_COMPARE_B, 8'h10);
    wr(tocu_pkg::OFF_COMPARE_A, 8'h06);
    rd_chk("buffer a", tocu_pkg::OFF_COMPARE_A, 8'h06);
    wr(tocu_pkg::OFF_COUNTER, 8'h0e);
    tick(3);
    rd_chk("old active", tocu_pkg::OFF_FLAGS, 8'h00);
    wr(tocu_pkg::OFF_COUNTER, 8'hfe);
    tick(2);
    tick(17);
    rd_chk("new active", tocu_pkg::OFF_FLAGS, 8'h07);
    wr(tocu_pkg::OFF_FLAGS, 8'h07);
    rd_chk("all cleared", tocu_pkg::OFF_FLAGS, 8'h00);
    // Clear-on-match: compare a is top and is written directly
    wr(tocu_pkg::OFF_MODE, 8'h0a);
    wr(tocu_pkg::OFF_COMPARE_A, 8'h03);
    rd_chk("direct a", tocu_pkg::OFF_COMPARE_A, 8'h03);
    wr(tocu_pkg::OFF_ACTION, {6'h00, tocu_pkg::ACT_TOGGLE});
    wr(tocu_pkg::OFF_COUNTER, 8'h00);
    tick(5);
    rd_chk("match clear", tocu_pkg::OFF_COUNTER, 8'h01);
    rd_chk("match flag", tocu_pkg::OFF_FLAGS, 8'h02);
    rd_chk("match toggle", tocu_pkg::OFF_STATE, 8'h01);
    // Phase correct: turns at maximum and counts down, output kept
    wr(tocu_pkg::OFF_MODE, 8'h09);
    wr(tocu_pkg::OFF_COUNTER, 8'hfe);
    tick(3);
    rd_chk("down count", tocu_pkg::OFF_COUNTER, 8'hfd);
    rd_chk("down state", tocu_pkg::OFF_STATE, 8'h05);
    // Reset in mid-run clears output states and mode
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(negedge clk_sys);
    rd_chk("reset state", tocu_pkg::OFF_STATE, 8'h00);
    rd_chk("reset mode", tocu_pkg::OFF_MODE, 8'h00);
    end_sim();
  end
endmodule

`default_nettype wire
